// ===== verilog/cisp_defines.svh
// Constants for the core interrupt setup and paging block.
// Assumes inclusion by bare name from the design files.
// Notes on behaviour
// [R1] Setup register loads from working register on setup-load with pointer bits 5,6 zero.
// [R2] Setup register is write-only and has no data address.
// [R3] Channel 3 flag follows edge/polarity bits 3 and 7: low, high, fall, rise.
// [R4] Channel 3 input is the peripheral controller line merging eight sources.
// [R5] Channel 2 flag follows bits 2 and 6 with the same encoding.
// [R6] Channel 2 input is the SMBus line merging seven event sources.
// [R7] Channel 1 senses the external pin per bits 1 and 5 when enabled.
// [R8] Software keeps the channel 1 sense enable bit at one.
// [R9] Setup bit 0 gates all peripheral addressing.
// [R10] Reset sets peripheral access enable to one.
// [R11] Program memory is four 512x12 blocks; block one is writable RAM.
// [R12] Two low page bits pick the block for jumps and calls.
// [R13] Program counter advances by one each instruction cycle.
// [R14] Jumps supply nine address bits plus the page bits.
// [R15] Calls supply eight bits, landing in the lower page half.
// [R16] Page bits affect flow only on a jump or call.
// [R17] Increment past page end carries on without touching page bits.
// [R18] Indirect slot accesses the register the pointer names.
// [R19] Pointer is eight bits; low five bits address 0x00 to 0x1F.
// [R20] Pointer bits 5 to 7 select one of eight data blocks.
// [R21] Page bits live in the status register with flags and interrupt off.
// [R22] Level modes set every cycle; edge modes once per transition.
// [R23] Flags stay set until cleared; a same-cycle event wins.
`ifndef CISP_DEFINES_SVH
`define CISP_DEFINES_SVH
`define CISP_SETUP_RESET 8'hff
`define CISP_SETUP_PADDR 0
`define CISP_SETUP_EN1 4
`define CISP_EDGE_LSB 1
`define CISP_POL_LSB 5
`define CISP_PTR_GATE_A 5
`define CISP_PTR_GATE_B 6
`define CISP_PTR_ADDR_MSB 4
`define CISP_PTR_BLK_LSB 5
`define CISP_ST_PAGE_LSB 5
`define CISP_ST_PAGE_W 3
`define CISP_PAGE_W 2
`define CISP_RAM_BASE 11'h200
`define CISP_RAM_LAST 11'h3ff
`define CISP_ST_RESET 8'h08
`define CISP_ADDR_INDIRECT 5'h00
`define CISP_ADDR_STATUS 5'h03
`define CISP_ADDR_POINTER 5'h04
`define CISP_ADDR_FLAGS 5'h05
`define CISP_PC_RESET 11'h7ff
`define CISP_PC_ONE 11'h001
`define CISP_RAM_BLOCK 2'h1
`define CISP_FLAG_LSB 1
`endif

// ===== verilog/cisp_pkg.sv
// Types for the core interrupt setup and paging block.
// Assumes nothing of its surroundings.
package cisp_pkg;
  typedef enum logic [1:0] {
    CISP_FLOW_SEQ = 2'b00,
    CISP_FLOW_JUMP = 2'b01,
    CISP_FLOW_CALL = 2'b11,
    CISP_FLOW_LOAD = 2'b10
  } cisp_flow_t;
endpackage

// ===== verilog/cisp_irq_channel.sv
// One interrupt trigger channel with a sticky flag.
// Assumes the input line is synchronous to the instruction clock.
`timescale 1ns/1ps
module cisp_irq_channel (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_line,
  input wire logic i_edge_mode,
  input wire logic i_polarity,
  input wire logic i_enable,
  input wire logic i_clear,
  output logic o_flag
);
  logic prev;
  logic flag;
  logic next_prev;
  logic next_flag;
  logic event_hit;

  always_comb begin
    // Pattern 00 low, 01 high, 10 falling, 11 rising.
    if (i_edge_mode) begin
      event_hit = i_polarity ? (i_line && !prev) : (!i_line && prev); // R22
    end else begin
      event_hit = (i_line == i_polarity); // R22
    end
    event_hit = event_hit && i_enable;
    next_prev = i_line;
    next_flag = event_hit ? 1'b1 : (i_clear ? 1'b0 : flag); // R23
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      prev <= 1'b0;
      flag <= 1'b0;
    end else if (i_ce) begin
      prev <= next_prev;
      flag <= next_flag;
    end
  end

  assign o_flag = flag;

  a_flag_set_wins: assert property ( // R23
    @(posedge i_clk_sys) disable iff (i_srst) i_ce && event_hit |=> flag)
    else $error("flag not set after event");
  a_flag_held: assert property ( // R23
    @(posedge i_clk_sys) disable iff (i_srst) flag && !i_clear |=> flag)
    else $error("flag dropped without clear");
endmodule

// ===== verilog/cisp_core.sv
// Interrupt setup register, program paging and indirect addressing.
// Assumes decoded instruction strobes synchronous to the instruction clock.
`timescale 1ns/1ps
`include "cisp_defines.svh"
module cisp_core #(
  parameter int PC_W = 11,
  parameter int DATA_W = 8,
  parameter int CH_N = 3
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic [DATA_W-1:0] i_work,
  input wire logic i_setup_load,
  input wire logic i_jump,
  input wire logic i_call,
  input wire logic [8:0] i_target,
  input wire logic i_load_pc,
  input wire logic [PC_W-1:0] i_load_value,
  input wire logic i_reg_write,
  input wire logic [4:0] i_reg_addr,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  input wire logic i_peripheral_irq_line,
  input wire logic i_smbus_irq_line,
  input wire logic i_external_irq_pin,
  output logic [PC_W-1:0] o_pc,
  output logic o_pc_in_ram,
  output logic [DATA_W-1:0] o_pointer,
  output logic [DATA_W-1:0] o_status,
  output logic [4:0] o_eff_addr,
  output logic [2:0] o_data_block,
  output logic o_periph_enable,
  output logic [CH_N-1:0] o_flags
);
  logic [DATA_W-1:0] setup;
  logic [DATA_W-1:0] pointer;
  logic [DATA_W-1:0] status;
  logic [PC_W-1:0] pc;
  logic [DATA_W-1:0] next_setup;
  logic [DATA_W-1:0] next_pointer;
  logic [DATA_W-1:0] next_status;
  logic [PC_W-1:0] next_pc;
  logic [4:0] eff_addr;
  logic [CH_N-1:0] flags;
  logic [CH_N-1:0] ch_line;
  logic [CH_N-1:0] ch_en;
  logic [CH_N-1:0] ch_clear;
  logic setup_take;
  logic [1:0] page;
  cisp_pkg::cisp_flow_t flow;

  // All checks in this module run on the instruction clock.
  default clocking cb_core @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);

  // Address decode that both the write path and the output share.
  function automatic logic [4:0] resolve(input logic [4:0] a,
                                         input logic [DATA_W-1:0] p);
    if (a == `CISP_ADDR_INDIRECT) begin
      resolve = p[`CISP_PTR_ADDR_MSB:0]; // R18 R19
    end else begin
      resolve = a;
    end
  endfunction

  // Write strobe decode shared by the register updates and flag clears.
  function automatic logic reg_hit(input logic wr, input logic [4:0] ea,
                                   input logic [4:0] a);
    reg_hit = wr && ea == a;
  endfunction

  assign eff_addr = resolve(i_reg_addr, pointer);
  assign page = status[`CISP_ST_PAGE_LSB +: `CISP_PAGE_W]; // R12 R21
  assign setup_take = i_setup_load && !pointer[`CISP_PTR_GATE_A]
    && !pointer[`CISP_PTR_GATE_B]; // R1

  always_comb begin
    if (i_load_pc) begin
      flow = cisp_pkg::CISP_FLOW_LOAD;
    end else if (i_jump) begin
      flow = cisp_pkg::CISP_FLOW_JUMP;
    end else if (i_call) begin
      flow = cisp_pkg::CISP_FLOW_CALL;
    end else begin
      flow = cisp_pkg::CISP_FLOW_SEQ;
    end
  end

  always_comb begin
    next_setup = setup;
    // Only the setup-load path writes this; no data address reaches it.
    if (setup_take) begin
      next_setup = i_work; // R1 R2
    end
    next_pointer = pointer;
    next_status = status;
    if (reg_hit(i_reg_write, eff_addr, `CISP_ADDR_POINTER)) begin
      next_pointer = i_reg_wdata; // R19 R20
    end
    if (reg_hit(i_reg_write, eff_addr, `CISP_ADDR_STATUS)) begin
      next_status = i_reg_wdata; // R21
    end
    unique case (flow)
      cisp_pkg::CISP_FLOW_SEQ: begin
        // Carry crosses blocks; page bits untouched.
        next_pc = pc + `CISP_PC_ONE; // R13 R16 R17
      end
      cisp_pkg::CISP_FLOW_JUMP: begin
        next_pc = {page, i_target}; // R12 R14
      end
      cisp_pkg::CISP_FLOW_CALL: begin
        next_pc = {page, 1'b0, i_target[7:0]}; // R15
      end
      cisp_pkg::CISP_FLOW_LOAD: begin
        next_pc = i_load_value;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      setup <= `CISP_SETUP_RESET; // R10
      pointer <= '0;
      status <= `CISP_ST_RESET;
      pc <= `CISP_PC_RESET;
    end else if (i_ce) begin
      setup <= next_setup;
      pointer <= next_pointer;
      status <= next_status;
      pc <= next_pc;
    end
  end

  // Channel 1 external pin, 2 SMBus line, 3 peripheral controller line.
  assign ch_line = {i_peripheral_irq_line, i_smbus_irq_line,
                    i_external_irq_pin}; // R4 R6
  assign ch_en = {2'b11, setup[`CISP_SETUP_EN1]}; // R7 R8

  genvar g;
  generate
    for (g = 0; g < CH_N; g++) begin : g_ch
      assign ch_clear[g] = reg_hit(i_reg_write, eff_addr, `CISP_ADDR_FLAGS)
        && !i_reg_wdata[`CISP_FLAG_LSB + g];
      cisp_irq_channel u_ch (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_line(ch_line[g]),
        .i_edge_mode(setup[`CISP_EDGE_LSB + g]), // R3 R5 R7
        .i_polarity(setup[`CISP_POL_LSB + g]),
        .i_enable(ch_en[g]),
        .i_clear(ch_clear[g]),
        .o_flag(flags[g])
      );
    end
  endgenerate

  assign o_pc = pc;
  // Block one of the four program blocks is the writable RAM.
  assign o_pc_in_ram = (pc[PC_W-1 -: 2] == `CISP_RAM_BLOCK); // R11
  assign o_pointer = pointer;
  assign o_status = status;
  assign o_eff_addr = eff_addr;
  assign o_data_block = pointer[`CISP_PTR_BLK_LSB +: 3]; // R20
  assign o_periph_enable = setup[`CISP_SETUP_PADDR]; // R9
  assign o_flags = flags;

  // Decoded steps that several checks below share.
  sequence s_seq_step;
    i_ce && flow == cisp_pkg::CISP_FLOW_SEQ;
  endsequence

  sequence s_jump_step;
    i_ce && flow == cisp_pkg::CISP_FLOW_JUMP;
  endsequence

  sequence s_call_step;
    i_ce && flow == cisp_pkg::CISP_FLOW_CALL;
  endsequence

  sequence s_ptr_write;
    i_ce && reg_hit(i_reg_write, eff_addr, `CISP_ADDR_POINTER);
  endsequence

  sequence s_status_write;
    i_ce && reg_hit(i_reg_write, eff_addr, `CISP_ADDR_STATUS);
  endsequence

  sequence s_frozen;
    !i_ce;
  endsequence

  // Program flow.
  a_pc_increments: assert property ( // R13
    s_seq_step |=> pc == $past(pc) + `CISP_PC_ONE)
    else $error("pc did not advance by one");
  a_page_kept: assert property ( // R17
    s_seq_step ##0 !reg_hit(i_reg_write, eff_addr, `CISP_ADDR_STATUS)
    |=> status == $past(status))
    else $error("page bits changed on sequential step");
  a_jump_target: assert property ( // R14
    s_jump_step |=> pc == {$past(page), $past(i_target)})
    else $error("jump target wrong");
  a_jump_page: assert property ( // R12
    s_jump_step |=> pc[PC_W-1 -: `CISP_PAGE_W]
    == $past(status[`CISP_ST_PAGE_LSB +: `CISP_PAGE_W]))
    else $error("jump left the page named by the status bits");
  a_call_lower: assert property ( // R15
    s_call_step |=> pc[8] == 1'b0 && pc[7:0] == $past(i_target[7:0]))
    else $error("call not in lower half");
  a_call_page: assert property ( // R15
    s_call_step |=> pc[PC_W-1 -: `CISP_PAGE_W] == $past(page))
    else $error("call left the page named by the status bits");
  a_load_target: assert property ( // R16
    i_ce && flow == cisp_pkg::CISP_FLOW_LOAD |=> pc == $past(i_load_value))
    else $error("loaded pc wrong");
  a_ram_window: assert property ( // R11 R12
    o_pc_in_ram == (pc >= `CISP_RAM_BASE && pc <= `CISP_RAM_LAST))
    else $error("ram block indication wrong");

  // Setup register.
  a_setup_gate: assert property ( // R1
    i_ce && i_setup_load && (pointer[`CISP_PTR_GATE_A]
    || pointer[`CISP_PTR_GATE_B]) |=> setup == $past(setup))
    else $error("setup loaded with gate bits set");
  a_setup_load: assert property ( // R1
    i_ce && setup_take |=> setup == $past(i_work))
    else $error("setup not loaded");
  a_setup_hold: assert property ( // R2
    i_ce && !setup_take |=> setup == $past(setup))
    else $error("setup changed without a setup load");
  a_periph_gate: assert property ( // R9
    i_ce && setup_take |=> o_periph_enable
    == $past(i_work[`CISP_SETUP_PADDR]))
    else $error("peripheral enable does not follow setup bit zero");
  a_periph_reset: assert property ( // R10
    disable iff (1'b0) i_srst |=> o_periph_enable)
    else $error("peripheral enable low after reset");

  // Data addressing.
  a_indirect_map: assert property ( // R18
    i_reg_addr == `CISP_ADDR_INDIRECT
    |-> eff_addr == pointer[`CISP_PTR_ADDR_MSB:0])
    else $error("indirect slot not redirected");
  a_direct_map: assert property ( // R18
    i_reg_addr != `CISP_ADDR_INDIRECT |-> eff_addr == i_reg_addr)
    else $error("direct address altered");
  a_pointer_write: assert property ( // R19
    s_ptr_write |=> pointer == $past(i_reg_wdata))
    else $error("pointer write lost");
  a_pointer_hold: assert property ( // R19
    i_ce && !reg_hit(i_reg_write, eff_addr, `CISP_ADDR_POINTER)
    |=> pointer == $past(pointer))
    else $error("pointer changed without a write");
  a_status_write: assert property ( // R21
    s_status_write |=> status == $past(i_reg_wdata))
    else $error("status write lost");

  // Clock enable.
  a_freeze_state: assert property ( // R13
    s_frozen |=> pc == $past(pc) && setup == $past(setup)
    && pointer == $past(pointer) && status == $past(status)
    && flags == $past(flags))
    else $error("state moved while the clock enable was low");

  // Interrupt channels, checked from the setup bits and the lines.
  a_ch1_gated: assert property ( // R7
    i_ce && !setup[`CISP_SETUP_EN1] && !flags[0] |=> !flags[0])
    else $error("channel one set while sensing is off");

  generate
    for (g = 0; g < CH_N; g++) begin : g_chk
      localparam int EB = `CISP_EDGE_LSB + g;
      localparam int PB = `CISP_POL_LSB + g;
      a_level_sets: assert property ( // R22
        i_ce && ch_en[g] && !setup[EB] && ch_line[g] == setup[PB]
        |=> flags[g])
        else $error("level match did not set the flag");
      a_level_quiet: assert property ( // R3 R5
        i_ce && !flags[g] && !setup[EB] && ch_line[g] != setup[PB]
        |=> !flags[g])
        else $error("flag set without a level match");
      a_rise_sets: assert property ( // R22
        (i_ce && !ch_line[g]) ##1 (i_ce && ch_line[g] && ch_en[g]
        && setup[EB] && setup[PB]) |=> flags[g])
        else $error("rising edge did not set the flag");
      a_fall_sets: assert property ( // R22
        (i_ce && ch_line[g]) ##1 (i_ce && !ch_line[g] && ch_en[g]
        && setup[EB] && !setup[PB]) |=> flags[g])
        else $error("falling edge did not set the flag");
      a_edge_quiet: assert property ( // R22
        i_ce ##1 (i_ce && !flags[g] && setup[EB]
        && ch_line[g] == $past(ch_line[g])) |=> !flags[g])
        else $error("flag set without an edge");
      a_clear_edge: assert property ( // R23
        i_ce ##1 (i_ce && ch_clear[g] && setup[EB]
        && ch_line[g] == $past(ch_line[g])) |=> !flags[g])
        else $error("flag not cleared in edge mode");
      a_clear_level: assert property ( // R23
        i_ce && ch_clear[g] && !setup[EB] && ch_line[g] != setup[PB]
        |=> !flags[g])
        else $error("flag not cleared in level mode");
    end
  endgenerate
endmodule

// ===== tb/cisp_far_model.sv
// Far side of the core: the on-chip interrupt sources merged onto the
// two interrupt lines, and the external interrupt pin.
// Assumes the bench moves the sources just after a clock edge.
`timescale 1ns/1ps
module cisp_far_model (
  input wire logic [7:0] i_src3,
  input wire logic [6:0] i_src2,
  input wire logic i_pin,
  output logic o_line3,
  output logic o_line2,
  output logic o_pin
);
  assign o_line3 = |i_src3;
  assign o_line2 = |i_src2;
  assign o_pin = i_pin;
endmodule

// ===== tb/cisp_core_test.sv
// Self-checking bench for the interrupt setup, paging and pointer core.
// Assumes the far-side model file and a 25 MHz instruction clock.
`timescale 1ns/1ps
module cisp_core_test;
  logic i_clk_sys = 0, i_srst = 1, i_ce = 1;
  logic i_setup_load = 0, i_jump = 0, i_call = 0, i_load_pc = 0;
  logic i_reg_write = 0, pin = 0, e, p, l3, l2, l1;
  logic [7:0] i_work = 0, i_reg_wdata = 0, src3 = 0, o_pointer, o_status;
  logic [8:0] i_target = 0;
  logic [10:0] i_load_value = 0, o_pc, q;
  logic [4:0] i_reg_addr = 0, o_eff_addr;
  logic [6:0] src2 = 0;
  logic [2:0] o_data_block, o_flags;
  logic [1:0] pg;
  logic o_pc_in_ram, o_periph_enable;
  int err_total = 0, n_compared = 0, m;
  cisp_far_model far_u (.i_src3(src3), .i_src2(src2), .i_pin(pin),
    .o_line3(l3), .o_line2(l2), .o_pin(l1));
  cisp_core dut_u (.i_clk_sys, .i_srst, .i_ce, .i_work, .i_setup_load,
    .i_jump, .i_call, .i_target, .i_load_pc, .i_load_value, .i_reg_write,
    .i_reg_addr, .i_reg_wdata, .i_peripheral_irq_line(l3),
    .i_smbus_irq_line(l2), .i_external_irq_pin(l1), .o_pc, .o_pc_in_ram,
    .o_pointer, .o_status, .o_eff_addr, .o_data_block, .o_periph_enable,
    .o_flags);
  initial forever #20 i_clk_sys = ~i_clk_sys;
  task tick;
    @(posedge i_clk_sys);
  endtask
  task chk(input logic [10:0] g, input logic [10:0] x);
    n_compared++;
    if (g !== x) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, g, x);
    end
  endtask
  task wreg(input logic [4:0] a, input logic [7:0] d);
    tick;
    i_reg_write <= 1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    tick;
    i_reg_write <= 0;
    #1;
  endtask
  task setl(input logic [7:0] d);
    tick;
    i_setup_load <= 1;
    i_work <= d;
    tick;
    i_setup_load <= 0;
    #1;
  endtask
  task pcop(input logic [2:0] k, input logic [10:0] v);
    tick;
    {i_load_pc, i_jump, i_call} <= k;
    i_target <= v[8:0];
    i_load_value <= v;
    tick;
    {i_load_pc, i_jump, i_call} <= 3'b000;
    #1;
  endtask
  // A different source in each merge group raises the line per mode.
  task lines(input logic v);
    tick;
    src3 <= v ? 8'h80 >> m : 8'h00;
    src2 <= v ? 7'h01 << m : 7'h00;
    pin <= v;
  endtask
  task final_report;
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) tick;
    err_total++;
    final_report;
  end
  initial begin
    repeat (6) tick;
    i_srst <= 0;
    #1;
    chk(o_status, 11'h008);
    chk(o_periph_enable, 1);
    chk(o_flags, 0);
    wreg(5'h04, 8'he3);
    chk(o_pointer, 11'h0e3);
    chk(o_data_block, 7);
    tick;
    i_reg_addr <= 5'h00;
    #1;
    chk(o_eff_addr, 3);
    wreg(5'h00, 8'h48);
    chk(o_status[7:5], 3'b010);
    setl(8'h00);
    chk(o_periph_enable, 1);
    wreg(5'h07, 8'h00);
    chk(o_periph_enable, 1);
    wreg(5'h04, 8'h80);
    setl(8'hfe);
    chk(o_periph_enable, 0);
    setl(8'hff);
    for (m = 0; m < 4; m++) begin
      {e, p} = m[1:0];
      setl({p, p, p, 1'b1, e, e, e, 1'b1});
      lines(~p);
      repeat (3) tick;
      wreg(5'h05, 8'h00);
      chk(o_flags, 0);
      lines(p);
      repeat (3) tick;
      #1;
      chk(o_flags, 7);
      wreg(5'h05, 8'h00);
      tick;
      #1;
      chk(o_flags, e ? 0 : 7);
    end
    setl(8'he1);
    wreg(5'h05, 8'h00);
    repeat (2) tick;
    #1;
    chk(o_flags, 3'b110);
    setl(8'h73);
    wreg(5'h05, 8'h00);
    tick;
    #1;
    chk(o_flags, 3'b010);
    setl(8'hff);
    for (m = 0; m < 4; m++) begin
      pg = m[1:0];
      wreg(5'h03, {1'b1, pg, 5'h08});
      q = o_pc;
      tick;
      #1;
      chk(o_pc, q + 1);
      chk(o_status[7:5], {1'b1, pg});
      pcop(3'b010, 11'h1f0);
      chk(o_pc, {pg, 9'h1f0});
      chk(o_pc_in_ram, pg == 1);
      pcop(3'b001, 11'h1ab);
      chk(o_pc, {pg, 9'h0ab});
    end
    pcop(3'b100, 11'h1fe);
    tick;
    #1;
    chk(o_pc, 11'h1ff);
    tick;
    #1;
    chk(o_pc, 11'h200);
    pcop(3'b010, 11'h005);
    chk(o_pc, 11'h605);
    setl(8'hfe);
    chk(o_periph_enable, 0);
    tick;
    i_ce <= 0;
    #1;
    q = o_pc;
    setl(8'hff);
    chk(o_pc, q);
    chk(o_periph_enable, 0);
    tick;
    i_ce <= 1;
    i_srst <= 1;
    tick;
    i_srst <= 0;
    #1;
    chk(o_periph_enable, 1);
    chk(o_pc, 11'h7ff);
    final_report;
  end
endmodule
